// [logic/mlc_defines.vh]
/*
  Constants for the module low-speed control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 125 MHz core clock and a 32-bit Avalon-MM slave with waitrequest.
*/
// Functional notes
// - The module answers 2-wire management traffic only while module select is held low, else it ignores the bus.
// - A reset pin low for longer than the minimum pulse performs a complete reset restoring default settings; the code keeps the pulse and init lengths.
// - Reset completion is signalled by asserting the interrupt with the not-ready flag negated; the code asserts it only when mask bit 0 is set.
// - On power-up the completion interrupt is posted without any reset pulse from the host; the code posts status bit 0, and the pin only if mask bit 0 is set.
// - The init-mode input is pulled up internally so that an undriven input selects software control.
// - With init-mode high the module stays in low power until software enables high power.
// - With init-mode low the module enters high power by itself once management init is done.
// - The module ties the present line low while inserted.
// - The module pulls the interrupt output low to flag a fault or critical status; the code does so only when mask bit 1 is set.
// - The interrupt output is open collector, only pulling low or releasing, with a host pull-up.
// - The host reads and writes the management memory map over the 2-wire clock and data lines.
`ifndef MLC_DEFINES_VH
`define MLC_DEFINES_VH

`define MLC_OFF_STATUS    8'h00
`define MLC_OFF_MASK      8'h04
`define MLC_OFF_CTRL      8'h08
`define MLC_OFF_STATE     8'h0C
`define MLC_OFF_MINPULSE  8'h10
`define MLC_OFF_INITCYC   8'h14
`define MLC_OFF_FAULT     8'h18

`define MLC_EV_RESET_DONE 0
`define MLC_EV_FAULT      1
`define MLC_EV_SEL_CHANGE 2
`define MLC_EV_WIDTH      3

`define MLC_CTRL_HIPWR    0
`define MLC_CTRL_SWRST    1

`define MLC_MASK_RST      3'h0
`define MLC_MINPULSE_RST  16'h04E2
`define MLC_INITCYC_RST   16'h0100
`define MLC_SYNC_STAGES   2

`define MLC_I2C_ADDR      7'h50
`define MLC_MAP_DEPTH     16
`define MLC_MAP_AW        4

`endif

// [logic/mlc_sync.v]
/*
  Two-flop level synchroniser for one bit.
  Assumes the input may change at any time relative to clk.
*/
`timescale 1ns/1ps
`include "mlc_defines.vh"
module mlc_sync (
  clk,
  rst,
  rst_val,
  d,
  q
);
  input  wire clk;
  input  wire rst;
  input  wire rst_val;
  input  wire d;
  output wire q;

  reg meta_reg;
  reg q_reg;

  // Reset value fixed per instance by a tie-off, so it is a constant
  always @(posedge clk) begin
    if (rst) begin
      meta_reg <= rst_val;
      q_reg    <= rst_val;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule

// [logic/mlc_i2c_slave.v]
/*
  2-wire management slave for a small byte memory map.
  Assumes SCL/SDA already synchronised; SDA is open drain via oe.
*/
`timescale 1ns/1ps
`include "mlc_defines.vh"
module mlc_i2c_slave (
  clk,
  rst,
  enable,
  scl,
  sda_in,
  sda_oe,
  rd_addr,
  rd_data,
  wr_en,
  wr_addr,
  wr_data
);
  input  wire                    clk;
  input  wire                    rst;
  input  wire                    enable;
  input  wire                    scl;
  input  wire                    sda_in;
  output reg                     sda_oe;
  output wire [`MLC_MAP_AW-1:0]  rd_addr;
  input  wire [7:0]              rd_data;
  output reg                     wr_en;
  output reg  [`MLC_MAP_AW-1:0]  wr_addr;
  output reg  [7:0]              wr_data;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_DEV  = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_WR   = 3'h3;
  localparam [2:0] ST_RD   = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;

  reg [2:0]             state_reg;
  reg                   scl_d_reg;
  reg                   sda_d_reg;
  reg [7:0]             shift_reg;
  reg [3:0]             bit_reg;
  reg                   rnw_reg;
  reg                   have_addr_reg;
  reg [`MLC_MAP_AW-1:0] ptr_reg;

  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_c  = scl & scl_d_reg & sda_d_reg & ~sda_in;
  wire stop_c   = scl & scl_d_reg & ~sda_d_reg & sda_in;

  assign rd_addr = ptr_reg;

  always @(posedge clk) begin
    if (rst) begin
      state_reg     <= ST_IDLE;
      scl_d_reg     <= 1'b1;
      sda_d_reg     <= 1'b1;
      shift_reg     <= 8'h00;
      bit_reg       <= 4'h0;
      rnw_reg       <= 1'b0;
      have_addr_reg <= 1'b0;
      ptr_reg       <= {`MLC_MAP_AW{1'b0}};
      sda_oe        <= 1'b0;
      wr_en         <= 1'b0;
      wr_addr       <= {`MLC_MAP_AW{1'b0}};
      wr_data       <= 8'h00;
    end else begin
      scl_d_reg <= scl;
      sda_d_reg <= sda_in;
      wr_en     <= 1'b0;
      if (!enable || stop_c) begin
        // Deselect mid-transfer releases SDA at once
        state_reg <= ST_IDLE;
        sda_oe    <= 1'b0;
      end else if (start_c) begin
        state_reg     <= ST_DEV;
        bit_reg       <= 4'h0;
        have_addr_reg <= 1'b0;
        sda_oe        <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_DEV, ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_reg   <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              bit_reg <= 4'h0;
              if (state_reg == ST_DEV) begin
                if (shift_reg[7:1] == `MLC_I2C_ADDR) begin
                  rnw_reg   <= shift_reg[0];
                  sda_oe    <= 1'b1;
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                sda_oe <= 1'b1;
                state_reg <= ST_ACK;
                if (!have_addr_reg) begin
                  ptr_reg       <= shift_reg[`MLC_MAP_AW-1:0];
                  have_addr_reg <= 1'b1;
                end else begin
                  wr_en   <= 1'b1;
                  wr_addr <= ptr_reg;
                  wr_data <= shift_reg;
                  ptr_reg <= ptr_reg + 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (rnw_reg) begin
                shift_reg <= rd_data;
                sda_oe    <= ~rd_data[7];
                bit_reg   <= 4'h1;
                ptr_reg   <= ptr_reg + 1'b1;
                state_reg <= ST_RD;
              end else begin
                sda_oe    <= 1'b0;
                state_reg <= ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_reg == 4'h8) begin
                sda_oe    <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                sda_oe  <= ~shift_reg[7 - bit_reg[2:0]];
                bit_reg <= bit_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              state_reg <= sda_in ? ST_IDLE : ST_ACK;
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// [logic/mlc_top.v]
/*
  Low-speed control of a pluggable module: reset sequencing, power mode,
  present and interrupt pins, 2-wire map, and an Avalon-MM register view.
  Assumes one 125 MHz clock, synchronous active-high rst, and that the pin
  wires resolve from the output enables outside this design.
*/
`timescale 1ns/1ps
`include "mlc_defines.vh"
module mlc_top (
  clk,
  rst,
  avs_address,
  avs_read,
  avs_write,
  avs_writedata,
  avs_readdata,
  avs_waitrequest,
  irq,
  module_select_n,
  module_reset_n,
  init_control_select,
  init_pin_driven,
  scl_in,
  sda_in,
  sda_oe,
  module_present_n,
  module_present_oe,
  interrupt_out_n,
  interrupt_out_oe,
  high_power_en,
  data_not_ready
);
  input  wire        clk;
  input  wire        rst;
  input  wire [7:0]  avs_address;
  input  wire        avs_read;
  input  wire        avs_write;
  input  wire [31:0] avs_writedata;
  output reg  [31:0] avs_readdata;
  output reg         avs_waitrequest;
  output reg         irq;
  input  wire        module_select_n;
  input  wire        module_reset_n;
  input  wire        init_control_select;
  input  wire        init_pin_driven;
  input  wire        scl_in;
  input  wire        sda_in;
  output reg         sda_oe;
  output reg         module_present_n;
  output reg         module_present_oe;
  output reg         interrupt_out_n;
  output reg         interrupt_out_oe;
  output reg         high_power_en;
  output reg         data_not_ready;

  localparam [1:0] SQ_RESET = 2'h0;
  localparam [1:0] SQ_INIT  = 2'h1;
  localparam [1:0] SQ_LOWP  = 2'h2;
  localparam [1:0] SQ_HIGHP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  wire sel_n_s;
  wire rst_n_s;
  wire init_s;
  wire scl_s;
  wire sda_s;
  wire [4:0] raw_in;
  wire [4:0] sync_out;
  wire [4:0] sync_rv;
  // Undriven init-mode pin reads high, as an internal pull-up would
  wire init_pulled = init_pin_driven ? init_control_select : 1'b1;

  assign raw_in  = {module_select_n, module_reset_n, init_pulled, scl_in, sda_in};
  assign sync_rv = 5'h1F;

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      mlc_sync u_sync (
        .clk     (clk),
        .rst     (rst),
        .rst_val (sync_rv[gi]),
        .d       (raw_in[gi]),
        .q       (sync_out[gi])
      );
    end
  endgenerate

  assign {sel_n_s, rst_n_s, init_s, scl_s, sda_s} = sync_out;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [`MLC_EV_WIDTH-1:0] status_reg;
  reg [`MLC_EV_WIDTH-1:0] mask_reg;
  reg [1:0]               ctrl_reg;
  reg [15:0]              minpulse_reg;
  reg [15:0]              initcyc_reg;
  reg [1:0]               seq_reg;
  reg [15:0]              low_cnt_reg;
  reg [15:0]              init_cnt_reg;
  reg                     full_reset_reg;
  reg                     sel_d_reg;
  reg [7:0]               fault_reg;
  reg [7:0]               map_reg [0:`MLC_MAP_DEPTH-1];

  wire                    i2c_wr_en;
  wire [`MLC_MAP_AW-1:0]  i2c_wr_addr;
  wire [7:0]              i2c_wr_data;
  wire [`MLC_MAP_AW-1:0]  i2c_rd_addr;
  wire                    i2c_sda_oe;

  wire acc        = (avs_read | avs_write) & avs_waitrequest;
  // Write lands on the answer edge, where the master sees waitrequest low
  wire wr_acc     = avs_write & ~avs_waitrequest;
  // Long low on reset pin; shorter glitches are filtered out
  wire long_low   = ~rst_n_s && (low_cnt_reg >= minpulse_reg);
  wire sw_reset   = wr_acc && avs_address == `MLC_OFF_CTRL && avs_writedata[`MLC_CTRL_SWRST];
  wire do_reset   = full_reset_reg | sw_reset;
  wire init_done  = (seq_reg == SQ_INIT) && (init_cnt_reg >= initcyc_reg);
  // Write-one-to-clear bits, zero unless the status word is written
  wire [`MLC_EV_WIDTH-1:0] st_clr = (wr_acc && avs_address == `MLC_OFF_STATUS) ?
                                    avs_writedata[`MLC_EV_WIDTH-1:0] : {`MLC_EV_WIDTH{1'b0}};

  reg [`MLC_EV_WIDTH-1:0] ev;
  always @* begin
    ev = {`MLC_EV_WIDTH{1'b0}};
    ev[`MLC_EV_RESET_DONE] = init_done;
    ev[`MLC_EV_FAULT]      = |fault_reg;
    ev[`MLC_EV_SEL_CHANGE] = sel_n_s ^ sel_d_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Previous select level, for the change event
  always @(posedge clk) begin
    if (rst) begin
      sel_d_reg <= 1'b1;
    end else begin
      sel_d_reg <= sel_n_s;
    end
  end

  // Reset pulse qualification
  always @(posedge clk) begin
    if (rst) begin
      low_cnt_reg    <= 16'h0000;
      full_reset_reg <= 1'b0;
    end else begin
      if (rst_n_s) begin
        low_cnt_reg <= 16'h0000;
      end else if (low_cnt_reg != 16'hFFFF) begin
        low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
      full_reset_reg <= long_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer; rst is power-up, so completion posts unprompted
  always @(posedge clk) begin
    if (rst) begin
      seq_reg        <= SQ_RESET;
      init_cnt_reg   <= 16'h0000;
      data_not_ready <= 1'b1;
      high_power_en  <= 1'b0;
    end else if (do_reset) begin
      seq_reg        <= SQ_RESET;
      init_cnt_reg   <= 16'h0000;
      data_not_ready <= 1'b1;
      high_power_en  <= 1'b0;
    end else begin
      case (seq_reg)
        SQ_RESET: begin
          // Hold while the pin is still low
          if (rst_n_s) begin
            seq_reg <= SQ_INIT;
          end
        end
        SQ_INIT: begin
          init_cnt_reg <= init_cnt_reg + 16'h0001;
          if (init_done) begin
            data_not_ready <= 1'b0;
            seq_reg        <= init_s ? SQ_LOWP : SQ_HIGHP;
          end
        end
        SQ_LOWP: begin
          high_power_en <= 1'b0;
          if (!init_s || ctrl_reg[`MLC_CTRL_HIPWR]) begin
            seq_reg <= SQ_HIGHP;
          end
        end
        SQ_HIGHP: begin
          high_power_en <= 1'b1;
          if (init_s && !ctrl_reg[`MLC_CTRL_HIPWR]) begin
            seq_reg <= SQ_LOWP;
          end
        end
        default: begin
          seq_reg <= SQ_RESET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then answer
  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h0000_0000;
    case (avs_address)
      `MLC_OFF_STATUS:   rd_word = {29'h0, status_reg};
      `MLC_OFF_MASK:     rd_word = {29'h0, mask_reg};
      `MLC_OFF_CTRL:     rd_word = {30'h0, ctrl_reg};
      `MLC_OFF_STATE:    rd_word = {26'h0, init_s, ~sel_n_s, high_power_en, data_not_ready, seq_reg};
      `MLC_OFF_MINPULSE: rd_word = {16'h0, minpulse_reg};
      `MLC_OFF_INITCYC:  rd_word = {16'h0, initcyc_reg};
      `MLC_OFF_FAULT:    rd_word = {24'h0, fault_reg};
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  // Handshake runs on through a pin or software reset, so the host
  // can still read back defaults while the reset pin is held low
  always @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~acc;
      if (acc) begin
        avs_readdata <= rd_word;
      end
    end
  end

  // Pulse and init lengths survive a full reset; only rst restores them
  always @(posedge clk) begin
    if (rst) begin
      minpulse_reg <= `MLC_MINPULSE_RST;
      initcyc_reg  <= `MLC_INITCYC_RST;
    end else if (wr_acc && !do_reset) begin
      if (avs_address == `MLC_OFF_MINPULSE) begin
        minpulse_reg <= avs_writedata[15:0];
      end
      if (avs_address == `MLC_OFF_INITCYC) begin
        initcyc_reg <= avs_writedata[15:0];
      end
    end
  end

  // Full reset wins over any write landing in the same cycle
  always @(posedge clk) begin
    if (rst || do_reset) begin
      status_reg <= {`MLC_EV_WIDTH{1'b0}};
      mask_reg   <= `MLC_MASK_RST;
      ctrl_reg   <= 2'h0;
      fault_reg  <= 8'h00;
    end else begin
      // Set wins over write-one-to-clear
      status_reg <= ev | (status_reg & ~st_clr);
      if (wr_acc) begin
        case (avs_address)
          `MLC_OFF_MASK:  mask_reg  <= avs_writedata[`MLC_EV_WIDTH-1:0];
          `MLC_OFF_CTRL:  ctrl_reg  <= {1'b0, avs_writedata[`MLC_CTRL_HIPWR]};
          `MLC_OFF_FAULT: fault_reg <= avs_writedata[7:0];
          default:        fault_reg <= fault_reg;
        endcase
      end else if (i2c_wr_en && i2c_wr_addr == 4'h1) begin
        ctrl_reg[`MLC_CTRL_HIPWR] <= i2c_wr_data[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Management map as seen over the 2-wire bus
  reg [7:0] map_rd;
  always @* begin
    case (i2c_rd_addr)
      4'h0:    map_rd = {5'h0, high_power_en, init_s, data_not_ready};
      4'h1:    map_rd = {6'h0, ctrl_reg};
      4'h2:    map_rd = {5'h0, status_reg};
      4'h3:    map_rd = fault_reg;
      default: map_rd = map_reg[i2c_rd_addr];
    endcase
  end

  generate
    for (gi = 0; gi < `MLC_MAP_DEPTH; gi = gi + 1) begin : g_map
      always @(posedge clk) begin
        if (rst || do_reset) begin
          map_reg[gi] <= 8'h00;
        end else if (i2c_wr_en && i2c_wr_addr == gi) begin
          map_reg[gi] <= i2c_wr_data;
        end
      end
    end
  endgenerate

  mlc_i2c_slave u_i2c (
    .clk     (clk),
    .rst     (rst),
    .enable  (~sel_n_s),
    .scl     (scl_s),
    .sda_in  (sda_s),
    .sda_oe  (i2c_sda_oe),
    .rd_addr (i2c_rd_addr),
    .rd_data (map_rd),
    .wr_en   (i2c_wr_en),
    .wr_addr (i2c_wr_addr),
    .wr_data (i2c_wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt
  always @(posedge clk) begin
    if (rst) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= i2c_sda_oe & ~sel_n_s;
    end
  end

  // Present line tied low from the first edge of rst on
  always @(posedge clk) begin
    if (rst) begin
      module_present_n  <= 1'b0;
      module_present_oe <= 1'b1;
    end else begin
      module_present_n  <= 1'b0;
      module_present_oe <= 1'b1;
    end
  end

  // Open collector: output level fixed low, only the enable moves
  wire int_any = |(status_reg & mask_reg);
  always @(posedge clk) begin
    if (rst) begin
      interrupt_out_n  <= 1'b0;
      interrupt_out_oe <= 1'b0;
      irq              <= 1'b0;
    end else begin
      irq              <= int_any;
      interrupt_out_n  <= 1'b0;
      interrupt_out_oe <= int_any;
    end
  end
endmodule

// [testbench/mlc_props.sv]
/*
  Checker for the low-speed control top: pin levels, interrupt and bus timing.
  Assumes one clock domain with synchronous active-high rst.
*/
`timescale 1ns/1ps
module mlc_props (
  input wire        clk,
  input wire        rst,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        irq,
  input wire        module_select_n,
  input wire        sda_oe,
  input wire        module_present_n,
  input wire        module_present_oe,
  input wire        interrupt_out_n,
  input wire        interrupt_out_oe,
  input wire        high_power_en,
  input wire        data_not_ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_present_tied: assert property (module_present_oe && !module_present_n)
    else $error("present line not held low");
  a_int_only_low: assert property (interrupt_out_n == 1'b0)
    else $error("interrupt pin driven high");
  a_int_follows_irq: assert property (interrupt_out_oe == irq)
    else $error("interrupt pin differs from irq");
  a_hp_after_init: assert property (data_not_ready && $past(data_not_ready) |-> !high_power_en)
    else $error("high power before init done");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered next cycle");
  a_sda_when_unsel: assert property (module_select_n [*5] |-> !sda_oe)
    else $error("sda driven while unselected");
  a_rd_stands: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("readdata changed outside answer");
endmodule

bind mlc_top mlc_props u_props (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .module_select_n(module_select_n), .sda_oe(sda_oe),
  .module_present_n(module_present_n), .module_present_oe(module_present_oe),
  .interrupt_out_n(interrupt_out_n), .interrupt_out_oe(interrupt_out_oe),
  .high_power_en(high_power_en), .data_not_ready(data_not_ready));

// [testbench/mlc_host.sv]
/*
  Host board model: pull-ups on present, interrupt and SDA, and a slow
  bit-banged 2-wire master. Assumes it is called just after a clock edge.
*/
`timescale 1ns/1ps
`include "mlc_defines.vh"
module mlc_host (
  input  wire clk,
  input  wire sda_oe,
  input  wire int_oe,
  input  wire prs_n,
  input  wire prs_oe,
  output wire scl,
  output wire sda,
  output wire int_pin,
  output wire prs_pin
);
  reg mc = 1'b1;
  reg md = 1'b1;
  assign scl     = mc;
  assign sda     = md & ~sda_oe;
  assign int_pin = int_oe ? 1'b0 : 1'b1;
  assign prs_pin = prs_oe ? prs_n : 1'b1;

  // Slow bit cell so the slave's synchronisers see each phase clearly
  task half;
    repeat (8) @(posedge clk);
  endtask
  task bitx(input b, output s);
    md <= b;
    half;
    mc <= 1'b1;
    half;
    s = sda;
    mc <= 1'b0;
    half;
  endtask
  task xbyte(input [7:0] b, inout int acks);
    bit s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    if (s === 1'b0) acks++;
  endtask
  task i2c_wr(input [7:0] ptr, input [7:0] dat, output int acks);
    acks = 0;
    md <= 1'b0;
    half;
    mc <= 1'b0;
    half;
    xbyte({`MLC_I2C_ADDR, 1'b0}, acks);
    xbyte(ptr, acks);
    xbyte(dat, acks);
    md <= 1'b0;
    half;
    mc <= 1'b1;
    half;
    md <= 1'b1;
    half;
  endtask
endmodule

// [testbench/tb_top.sv]
/*
  Self-checking bench for the low-speed control top.
  Assumes the host model resolves the open-drain pins.
*/
`timescale 1ns/1ps
`include "mlc_defines.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        module_select_n = 1'b1;
  logic        module_reset_n = 1'b1;
  logic        init_control_select = 1'b0;
  logic        init_pin_driven = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest, irq, sda_oe, module_present_n, module_present_oe;
  wire         interrupt_out_n, interrupt_out_oe, high_power_en, data_not_ready;
  wire         scl, sda, int_pin, prs_pin;
  logic [31:0] rd;
  int          failures = 0;
  int          cmp_count = 0;
  int          acks;

  mlc_top u_dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .module_select_n(module_select_n),
    .module_reset_n(module_reset_n), .init_control_select(init_control_select),
    .init_pin_driven(init_pin_driven), .scl_in(scl), .sda_in(sda), .sda_oe(sda_oe),
    .module_present_n(module_present_n), .module_present_oe(module_present_oe),
    .interrupt_out_n(interrupt_out_n), .interrupt_out_oe(interrupt_out_oe),
    .high_power_en(high_power_en), .data_not_ready(data_not_ready));
  mlc_host u_host (.clk(clk), .sda_oe(sda_oe), .int_oe(interrupt_out_oe), .prs_n(module_present_n),
    .prs_oe(module_present_oe), .scl(scl), .sda(sda), .int_pin(int_pin), .prs_pin(prs_pin));

  initial begin
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task wait_ready(input int lim);
    int n;
    n = 0;
    while (data_not_ready !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk("ready", data_not_ready, 1'b0);
  endtask
  task settle;
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_powerup;
    wr(`MLC_OFF_MASK, 32'h1);
    chk("nr_start", data_not_ready, 1'b1);
    chk("present", prs_pin, 1'b0);
    rdc("minpulse", `MLC_OFF_MINPULSE, 32'h04E2);
    rdc("initcyc", `MLC_OFF_INITCYC, 32'h0100);
    rdc("unmapped", 8'h40, 32'h0);
    wait_ready(400);
    settle;
    chk("int_done", int_pin, 1'b0);
    rdc("status_done", `MLC_OFF_STATUS, 32'h1);
    wr(`MLC_OFF_MASK, 32'h0);
    settle;
    chk("int_masked", int_pin, 1'b1);
    wr(`MLC_OFF_MASK, 32'h1);
    settle;
    chk("irq_unmask", irq, 1'b1);
    wr(`MLC_OFF_STATUS, 32'h1);
    settle;
    chk("irq_clear", irq, 1'b0);
  endtask
  task t_swmode;
    rdc("state_low", `MLC_OFF_STATE, 32'h22);
    repeat (20) @(posedge clk);
    chk("hp_wait", high_power_en, 1'b0);
    wr(`MLC_OFF_CTRL, 32'h1);
    settle;
    chk("hp_sw", high_power_en, 1'b1);
    rdc("state_high", `MLC_OFF_STATE, 32'h2B);
  endtask
  task t_select;
    u_host.i2c_wr(8'h01, 8'h00, acks);
    chk("acks_unsel", acks, 32'h0);
    rdc("ctrl_unsel", `MLC_OFF_CTRL, 32'h1);
    module_select_n <= 1'b0;
    settle;
    u_host.i2c_wr(8'h01, 8'h00, acks);
    chk("acks_sel", acks, 32'h3);
    rdc("ctrl_sel", `MLC_OFF_CTRL, 32'h0);
    chk("hp_sel", high_power_en, 1'b0);
    module_select_n <= 1'b1;
  endtask
  task t_pinreset;
    wr(`MLC_OFF_MINPULSE, 32'h4);
    wr(`MLC_OFF_INITCYC, 32'h8);
    wr(`MLC_OFF_CTRL, 32'h1);
    module_reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    module_reset_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk("short_nr", data_not_ready, 1'b0);
    chk("short_hp", high_power_en, 1'b1);
    // Mode pin moves only while the module is held in reset
    module_reset_n <= 1'b0;
    init_pin_driven <= 1'b1;
    init_control_select <= 1'b0;
    repeat (20) @(posedge clk);
    chk("long_nr", data_not_ready, 1'b1);
    chk("long_hp", high_power_en, 1'b0);
    rdc("mask_dflt", `MLC_OFF_MASK, 32'h0);
    rdc("ctrl_dflt", `MLC_OFF_CTRL, 32'h0);
    rdc("minpulse_kept", `MLC_OFF_MINPULSE, 32'h4);
    // Status is left unread until the reset has finished
    module_reset_n <= 1'b1;
    wait_ready(100);
    settle;
    chk("hp_hw", high_power_en, 1'b1);
  endtask
  task t_fault;
    wr(`MLC_OFF_MASK, 32'h2);
    wr(`MLC_OFF_FAULT, 32'h1);
    settle;
    chk("int_fault", int_pin, 1'b0);
    rdc("status_fault", `MLC_OFF_STATUS, 32'h3);
    wr(`MLC_OFF_FAULT, 32'h0);
    wr(`MLC_OFF_STATUS, 32'h2);
    settle;
    chk("irq_fault_clr", irq, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_powerup;
    t_swmode;
    t_select;
    t_pinreset;
    t_fault;
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule
